// *** common/hdlc_dma_pkg.sv ***
/*
 * Constants shared by the channel FIFO/DMA logic and its staging buffer.
 * Assumes one 100 MHz clock domain for all users.
 */
package hdlc_dma_pkg;

	// Pool geometry: two halves of 32 bytes per direction
	localparam int POOL_BYTES  = 64;
	localparam int HALF_BYTES  = 32;
	localparam int STAGE_DEPTH = 8;
	localparam int STAGE_WIDTH = 9;

	// Byte counts within one half
	localparam logic [5:0] CNT_ZERO  = 6'h00;
	localparam logic [5:0] CNT_ONE   = 6'h01;
	localparam logic [5:0] HALF_FULL = 6'h20;
	localparam logic [5:0] HALF_LAST = 6'h1f;

	// Transmit byte count
	localparam logic [11:0] TXREM_RST = 12'h000;
	localparam logic [11:0] TXREM_ONE = 12'h001;

	// Values after reset
	localparam logic [7:0] BYTE_RST       = 8'h00;
	localparam logic       PEER_READY_RST = 1'b1;
	localparam logic       CTS_IDLE_RST   = 1'b1;

	// Byte address inside a 64-byte pool
	function automatic logic [5:0] pool_addr(input logic half,
		input logic [4:0] idx);
		return {half, idx};
	endfunction : pool_addr

endpackage : hdlc_dma_pkg

// *** rtl/stage_fifo.sv ***
/*
 * Staging FIFO with valid/ready on both sides and a clock enable.
 * Assumes one clock; push and pop happen only while ce is high.
 */
`timescale 1ns/1ns
module stage_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             ce,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wp_reg, wp_next;
	logic [AW-1:0]    rp_reg, rp_next;
	logic [CW-1:0]    cnt_reg, cnt_next;
	logic             push;
	logic             pop;

	// Pointer step with wrap for any depth
	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : ptr_inc

	////////////////////////////////////////////////////////////////////
	// Handshakes and next state
	assign in_ready  = (cnt_reg != CW'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign out_data  = mem[rp_reg];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		wp_next  = push ? ptr_inc(wp_reg) : wp_reg;
		rp_next  = pop ? ptr_inc(rp_reg) : rp_reg;
		cnt_next = cnt_reg;
		if (push && !pop) begin
			cnt_next = cnt_reg + 1'b1;
		end else if (pop && !push) begin
			cnt_next = cnt_reg - 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Storage and pointers
	always_ff @(posedge clk) begin
		if (ce && push) begin
			mem[wp_reg] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wp_reg  <= '0;
			rp_reg  <= '0;
			cnt_reg <= '0;
		end else if (ce) begin
			wp_reg  <= wp_next;
			rp_reg  <= rp_next;
			cnt_reg <= cnt_next;
		end
	end

endmodule : stage_fifo

// *** rtl/hdlc_fifo_dma.sv ***
/*
 * One channel: 64-byte receive and transmit pools in 32-byte halves,
 * demand-mode DMA requests and the special-condition interrupt pulses.
 * Assumes bus strobes and serial-engine signals are on SYS_CLK; the
 * CTS pin is asynchronous. A dual-channel device uses two instances.
 */
`timescale 1ns/1ns
module hdlc_fifo_dma
	import hdlc_dma_pkg::*;
(
	input  wire logic        SYS_CLK,
	input  wire logic        RST,
	input  wire logic        CE,
	input  wire logic        DMA_MODE,
	input  wire logic        AUTO_MODE,
	input  wire logic        CTS_CHANGE_IRQ_ENABLE,
	input  wire logic        BUS_CS,
	input  wire logic        BUS_RD,
	input  wire logic        BUS_WR,
	input  wire logic [5:0]  BUS_ADDR,
	input  wire logic [7:0]  BUS_WDATA,
	output logic      [7:0]  BUS_RDATA,
	input  wire logic        DMA_ACKNOWLEDGE_INPUT,
	output logic             RECEIVE_DMA_REQUEST,
	output logic             TRANSMIT_DMA_REQUEST,
	input  wire logic        RECEIVE_BLOCK_RELEASE_CMD,
	input  wire logic        RX_START,
	input  wire logic        RX_VALID,
	input  wire logic        RX_END,
	input  wire logic [7:0]  RX_DATA,
	output logic             RX_READY,
	input  wire logic        TX_LOAD,
	input  wire logic [11:0] TX_COUNT,
	output logic             TX_VALID,
	output logic      [7:0]  TX_DATA,
	input  wire logic        TX_READY,
	input  wire logic        FRAME_RR,
	input  wire logic        FRAME_RNR,
	input  wire logic        FRAME_NR_BAD,
	input  wire logic        FRAME_S_IFIELD,
	input  wire logic        TIMER_EXPIRE,
	input  wire logic        REPEAT_DONE,
	input  wire logic        CTS_N,
	output logic             RECEIVE_POOL_FULL_IRQ,
	output logic             RECEIVE_MESSAGE_END_IRQ,
	output logic             RECEIVE_FRAME_OVERFLOW_IRQ,
	output logic             PEER_STATUS_CHANGE_IRQ,
	output logic             PROTOCOL_ERROR_IRQ,
	output logic             TIMER_EXPIRED_IRQ,
	output logic             CTS_CHANGE_IRQ
);
	logic [7:0] rx_mem [POOL_BYTES];
	logic [7:0] tx_mem [POOL_BYTES];

	logic       st_valid, st_ready;
	logic [8:0] st_data;
	logic       rx_swap, rx_rd_acc, rx_dma_rd, rx_last_rd, rx_release;
	logic [4:0] rx_idx;
	logic       rx_acc_half_reg, rx_acc_half_next;
	logic       rx_acc_valid_reg, rx_acc_valid_next;
	logic       rx_acc_end_reg, rx_acc_end_next;
	logic [5:0] rx_acc_len_reg, rx_acc_len_next;
	logic [5:0] rx_rptr_reg, rx_rptr_next;
	logic       rx_wr_half_reg, rx_wr_half_next;
	logic [5:0] rx_wcnt_reg, rx_wcnt_next;
	logic       rx_wend_reg, rx_wend_next;
	logic [7:0] rdata_reg, rdata_next;
	logic       rpf_reg, rpf_next, rme_reg, rme_next, rfo_reg, rfo_next;

	logic        tx_fill, tx_wr_acc, tx_last_wr, tx_hand, tx_shift;
	logic        tx_acc_half_reg, tx_acc_half_next;
	logic [5:0]  tx_wcnt_reg, tx_wcnt_next;
	logic [11:0] tx_rem_reg, tx_rem_next;
	logic        tx_full_reg, tx_full_next;
	logic        tx_busy_reg, tx_busy_next;
	logic        tx_ser_half_reg, tx_ser_half_next;
	logic [5:0]  tx_ser_len_reg, tx_ser_len_next;
	logic [5:0]  tx_sidx_reg, tx_sidx_next;
	logic        tx_val_reg, tx_val_next;
	logic [7:0]  tx_dat_reg, tx_dat_next;

	logic peer_ready_reg, peer_ready_next;
	logic cts_meta_reg, cts_sync_reg, cts_prev_reg;
	logic rsc_reg, rsc_next, pce_reg, pce_next;
	logic tin_reg, tin_next, csc_reg, csc_next;

	////////////////////////////////////////////////////////////////////
	// Staging buffer between serial receiver and receive pool
	stage_fifo #(
		.WIDTH (STAGE_WIDTH),
		.DEPTH (STAGE_DEPTH)
	) u_rx_stage (
		.clk       (SYS_CLK),
		.rst       (RST),
		.ce        (CE),
		.in_valid  (RX_VALID),
		.in_data   ({RX_END, RX_DATA}),
		.in_ready  (RX_READY),
		.out_valid (st_valid),
		.out_data  (st_data),
		.out_ready (st_ready)
	);

	////////////////////////////////////////////////////////////////////
	// Receive pool control
	// Hand the write half over once full or holding whole frames
	assign rx_swap = !rx_acc_valid_reg && (rx_wcnt_reg != CNT_ZERO) &&
		((rx_wcnt_reg == HALF_FULL) || rx_wend_reg);
	// Writer stalls on a full half, back-pressure reaches RX_READY
	assign st_ready = !rx_swap && (rx_wcnt_reg != HALF_FULL);
	assign rx_rd_acc = BUS_RD && rx_acc_valid_reg &&
		(DMA_ACKNOWLEDGE_INPUT || (BUS_CS && !BUS_ADDR[5]));
	assign rx_dma_rd  = rx_rd_acc && DMA_ACKNOWLEDGE_INPUT;
	assign rx_last_rd = rx_dma_rd &&
		((rx_rptr_reg + CNT_ONE) == rx_acc_len_reg);
	// DMA mode frees after the block is read; else by command
	assign rx_release = DMA_MODE ? rx_last_rd :
		(RECEIVE_BLOCK_RELEASE_CMD && rx_acc_valid_reg);
	// Acknowledged cycles use the internal pointer, no address
	assign rx_idx = DMA_ACKNOWLEDGE_INPUT ? rx_rptr_reg[4:0] :
		BUS_ADDR[4:0];
	// Level request, dropped as the final read begins
	assign RECEIVE_DMA_REQUEST = DMA_MODE && rx_acc_valid_reg &&
		!rx_last_rd;

	always_comb begin
		rx_acc_half_next  = rx_acc_half_reg;
		rx_acc_valid_next = rx_acc_valid_reg;
		rx_acc_end_next   = rx_acc_end_reg;
		rx_acc_len_next   = rx_acc_len_reg;
		rx_rptr_next      = rx_rptr_reg;
		rx_wr_half_next   = rx_wr_half_reg;
		rx_wcnt_next      = rx_wcnt_reg;
		rx_wend_next      = rx_wend_reg;
		rdata_next        = rdata_reg;
		if (rx_release) begin
			rx_acc_valid_next = 1'b0;
		end
		if (rx_swap) begin
			rx_acc_valid_next = 1'b1;
			rx_acc_half_next  = rx_wr_half_reg;
			rx_acc_len_next   = rx_wcnt_reg;
			rx_acc_end_next   = rx_wend_reg;
			rx_rptr_next      = CNT_ZERO;
			rx_wr_half_next   = !rx_wr_half_reg;
			rx_wcnt_next      = CNT_ZERO;
			rx_wend_next      = 1'b0;
		end
		if (rx_dma_rd) begin
			rx_rptr_next = rx_last_rd ? CNT_ZERO :
				rx_rptr_reg + CNT_ONE;
		end
		// Frames keep packing into the write half; status bytes marked
		if (st_valid && st_ready) begin
			rx_wcnt_next = rx_wcnt_reg + CNT_ONE;
			rx_wend_next = st_data[8];
		end
		if (rx_rd_acc) begin
			rdata_next = rx_mem[pool_addr(rx_acc_half_reg, rx_idx)];
		end
		rpf_next = rx_swap && !DMA_MODE && !rx_wend_reg;
		rme_next = (rx_swap && !DMA_MODE && rx_wend_reg) ||
			(rx_last_rd && DMA_MODE && rx_acc_end_reg);
		rfo_next = RX_START && rx_acc_valid_reg &&
			(rx_wcnt_reg == HALF_FULL);
	end

	always_ff @(posedge SYS_CLK) begin
		if (CE && st_valid && st_ready) begin
			rx_mem[pool_addr(rx_wr_half_reg, rx_wcnt_reg[4:0])] <=
				st_data[7:0];
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			rx_acc_half_reg  <= 1'b0;
			rx_acc_valid_reg <= 1'b0;
			rx_acc_end_reg   <= 1'b0;
			rx_acc_len_reg   <= CNT_ZERO;
			rx_rptr_reg      <= CNT_ZERO;
			rx_wr_half_reg   <= 1'b0;
			rx_wcnt_reg      <= CNT_ZERO;
			rx_wend_reg      <= 1'b0;
			rdata_reg        <= BYTE_RST;
			rpf_reg          <= 1'b0;
			rme_reg          <= 1'b0;
			rfo_reg          <= 1'b0;
		end else if (CE) begin
			rx_acc_half_reg  <= rx_acc_half_next;
			rx_acc_valid_reg <= rx_acc_valid_next;
			rx_acc_end_reg   <= rx_acc_end_next;
			rx_acc_len_reg   <= rx_acc_len_next;
			rx_rptr_reg      <= rx_rptr_next;
			rx_wr_half_reg   <= rx_wr_half_next;
			rx_wcnt_reg      <= rx_wcnt_next;
			rx_wend_reg      <= rx_wend_next;
			rdata_reg        <= rdata_next;
			rpf_reg          <= rpf_next;
			rme_reg          <= rme_next;
			rfo_reg          <= rfo_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Transmit pool control
	assign tx_fill = !tx_full_reg && (tx_rem_reg != TXREM_RST);
	assign tx_wr_acc = BUS_WR && tx_fill &&
		(DMA_ACKNOWLEDGE_INPUT || (BUS_CS && BUS_ADDR[5]));
	assign tx_last_wr = tx_wr_acc &&
		((tx_wcnt_reg == HALF_LAST) || (tx_rem_reg == TXREM_ONE));
	// Held until the closing write of the block starts
	assign TRANSMIT_DMA_REQUEST = DMA_MODE && tx_fill &&
		!tx_last_wr;
	assign tx_hand  = tx_full_reg && !tx_busy_reg;
	assign tx_shift = tx_busy_reg && (!tx_val_reg || TX_READY);
	assign TX_VALID = tx_val_reg;
	assign TX_DATA  = tx_dat_reg;

	always_comb begin
		tx_acc_half_next = tx_acc_half_reg;
		tx_wcnt_next     = tx_wcnt_reg;
		tx_rem_next      = tx_rem_reg;
		tx_full_next     = tx_full_reg;
		tx_busy_next     = tx_busy_reg;
		tx_ser_half_next = tx_ser_half_reg;
		tx_ser_len_next  = tx_ser_len_reg;
		tx_sidx_next     = tx_sidx_reg;
		tx_val_next      = tx_val_reg;
		tx_dat_next      = tx_dat_reg;
		if (tx_wr_acc) begin
			tx_wcnt_next = tx_wcnt_reg + CNT_ONE;
			tx_rem_next  = tx_rem_reg - TXREM_ONE;
			tx_full_next = tx_last_wr;
		end
		if (TX_LOAD) begin
			tx_rem_next = TX_COUNT;
		end
		// Filled half goes to the serial side, the other opens
		if (tx_hand) begin
			tx_busy_next     = 1'b1;
			tx_ser_half_next = tx_acc_half_reg;
			tx_ser_len_next  = tx_wcnt_reg;
			tx_sidx_next     = CNT_ZERO;
			tx_acc_half_next = !tx_acc_half_reg;
			tx_wcnt_next     = CNT_ZERO;
			tx_full_next     = 1'b0;
		end
		if (tx_shift) begin
			tx_dat_next  = tx_mem[pool_addr(tx_ser_half_reg,
				tx_sidx_reg[4:0])];
			tx_val_next  = 1'b1;
			tx_sidx_next = tx_sidx_reg + CNT_ONE;
			if ((tx_sidx_reg + CNT_ONE) == tx_ser_len_reg) begin
				tx_busy_next = 1'b0;
			end
		end else if (TX_READY) begin
			tx_val_next = 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (CE && tx_wr_acc) begin
			tx_mem[pool_addr(tx_acc_half_reg, tx_wcnt_reg[4:0])] <=
				BUS_WDATA;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			tx_acc_half_reg <= 1'b0;
			tx_wcnt_reg     <= CNT_ZERO;
			tx_rem_reg      <= TXREM_RST;
			tx_full_reg     <= 1'b0;
			tx_busy_reg     <= 1'b0;
			tx_ser_half_reg <= 1'b0;
			tx_ser_len_reg  <= CNT_ZERO;
			tx_sidx_reg     <= CNT_ZERO;
			tx_val_reg      <= 1'b0;
			tx_dat_reg      <= BYTE_RST;
		end else if (CE) begin
			tx_acc_half_reg <= tx_acc_half_next;
			tx_wcnt_reg     <= tx_wcnt_next;
			tx_rem_reg      <= tx_rem_next;
			tx_full_reg     <= tx_full_next;
			tx_busy_reg     <= tx_busy_next;
			tx_ser_half_reg <= tx_ser_half_next;
			tx_ser_len_reg  <= tx_ser_len_next;
			tx_sidx_reg     <= tx_sidx_next;
			tx_val_reg      <= tx_val_next;
			tx_dat_reg      <= tx_dat_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Special-condition interrupts
	always_comb begin
		peer_ready_next = peer_ready_reg;
		if (FRAME_RR) begin
			peer_ready_next = 1'b1;
		end else if (FRAME_RNR) begin
			peer_ready_next = 1'b0;
		end
		rsc_next = AUTO_MODE && ((FRAME_RR && !peer_ready_reg) ||
			(FRAME_RNR && peer_ready_reg));
		pce_next = AUTO_MODE &&
			(FRAME_NR_BAD || FRAME_S_IFIELD);
		tin_next = TIMER_EXPIRE && REPEAT_DONE;
		csc_next = CTS_CHANGE_IRQ_ENABLE &&
			(cts_sync_reg != cts_prev_reg);
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			peer_ready_reg <= PEER_READY_RST;
			cts_meta_reg   <= CTS_IDLE_RST;
			cts_sync_reg   <= CTS_IDLE_RST;
			cts_prev_reg   <= CTS_IDLE_RST;
			rsc_reg        <= 1'b0;
			pce_reg        <= 1'b0;
			tin_reg        <= 1'b0;
			csc_reg        <= 1'b0;
		end else if (CE) begin
			peer_ready_reg <= peer_ready_next;
			cts_meta_reg   <= CTS_N;
			cts_sync_reg   <= cts_meta_reg;
			cts_prev_reg   <= cts_sync_reg;
			rsc_reg        <= rsc_next;
			pce_reg        <= pce_next;
			tin_reg        <= tin_next;
			csc_reg        <= csc_next;
		end
	end

	// Registered outputs
	assign BUS_RDATA                  = rdata_reg;
	assign RECEIVE_POOL_FULL_IRQ      = rpf_reg;
	assign RECEIVE_MESSAGE_END_IRQ    = rme_reg;
	assign RECEIVE_FRAME_OVERFLOW_IRQ = rfo_reg;
	assign PEER_STATUS_CHANGE_IRQ     = rsc_reg;
	assign PROTOCOL_ERROR_IRQ         = pce_reg;
	assign TIMER_EXPIRED_IRQ          = tin_reg;
	assign CTS_CHANGE_IRQ             = csc_reg;

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);

	a_rsc_auto_only: assert property (
		$past(CE) && PEER_STATUS_CHANGE_IRQ |-> $past(AUTO_MODE) &&
		(($past(FRAME_RR) && !$past(peer_ready_reg)) ||
		($past(FRAME_RNR) && $past(peer_ready_reg))))
		else $error("peer status change without cause");
	a_pce_cause: assert property (
		$past(CE) && PROTOCOL_ERROR_IRQ |-> $past(AUTO_MODE) &&
		($past(FRAME_NR_BAD) || $past(FRAME_S_IFIELD)))
		else $error("protocol error without cause");
	a_tin_expiry: assert property (
		CE && TIMER_EXPIRE && REPEAT_DONE |=> TIMER_EXPIRED_IRQ)
		else $error("timer expiry not reported");
	a_csc_enable: assert property (
		$past(CE) && CTS_CHANGE_IRQ |-> $past(CTS_CHANGE_IRQ_ENABLE))
		else $error("cts change reported while disabled");
	a_receive_dma_request_drop: assert property (
		CE && rx_last_rd |-> !RECEIVE_DMA_REQUEST ##1 !RECEIVE_DMA_REQUEST)
		else $error("receive request held on final read");
	a_receive_dma_request_level: assert property (
		RECEIVE_DMA_REQUEST && !rx_rd_acc |=>
		RECEIVE_DMA_REQUEST || rx_last_rd || !DMA_MODE)
		else $error("receive request dropped without read");
	a_rx_release: assert property (
		CE && DMA_MODE && rx_last_rd |=> !rx_acc_valid_reg)
		else $error("receive block not released after readout");
	a_half_bound: assert property (
		rx_wcnt_reg <= HALF_FULL && tx_wcnt_reg <= HALF_FULL)
		else $error("half count beyond 32");
	a_transmit_dma_request_cond: assert property (
		TRANSMIT_DMA_REQUEST |-> DMA_MODE &&
		tx_rem_reg != TXREM_RST && !tx_full_reg)
		else $error("transmit request without room or count");
	a_tx_handover: assert property (
		CE && tx_hand |=> tx_busy_reg && tx_wcnt_reg == CNT_ZERO)
		else $error("transmit half not handed over");
	a_rfo_cause: assert property (
		$past(CE) && RECEIVE_FRAME_OVERFLOW_IRQ |-> $past(RX_START) &&
		$past(rx_wcnt_reg) == HALF_FULL)
		else $error("overflow without full pool");
	a_rpf_intmode: assert property (
		$past(CE) && RECEIVE_POOL_FULL_IRQ |-> !$past(DMA_MODE))
		else $error("pool full raised in dma mode");

	c_rx_dma_block: cover property (CE && DMA_MODE && rx_last_rd);
	c_rx_int_full: cover property (RECEIVE_POOL_FULL_IRQ);
	c_tx_hand: cover property (CE && tx_hand);
	c_overflow: cover property (RECEIVE_FRAME_OVERFLOW_IRQ);

endmodule : hdlc_fifo_dma

// *** testbench/dma_ctrl_model.sv ***
/* Demand-mode DMA controller with acknowledge, on the channel's bus side.
   Assumes strobes are sampled on the rising edge of clk. */
`timescale 1ns/1ns
module dma_ctrl_model (
	input  wire logic       clk,
	input  wire logic       en,
	input  wire logic       slow,
	input  wire logic       rx_req,
	input  wire logic       tx_req,
	output logic            ack,
	output logic            rd,
	output logic            wr,
	output logic      [7:0] wd
);
	logic qr = 0;
	logic qt = 0;
	logic ph = 0;
	logic go;
	int   n = 0;
	////////////////////////////////////////////////////////////////////
	// Requests as they stood before the edge; count taken writes
	always @(posedge clk) begin
		qr <= rx_req;
		qt <= tx_req;
		ph <= ~ph;
		if (ack & wr)
			n <= n + 1;
	end
	// One byte a cycle while requested; slow idles every other cycle
	initial {ack, rd, wr, wd} = '0;
	always @(posedge clk) begin
		#1;
		go = en & ~(slow & ph);
		ack <= go & (qr | qt);
		rd <= go & qr;
		wr <= go & ~qr & qt;
		wd <= (go & ~qr & qt) ? 8'ha0 + n[7:0] : ~wd; // Idle: not last
	end
endmodule : dma_ctrl_model

// *** testbench/hdlc_fifo_dma_test.sv ***
/* Bench for hdlc_fifo_dma: receive/transmit DMA, reads, event pulses.
   Assumes the DMA controller model and a 100 MHz clock. */
`timescale 1ns/1ns
module hdlc_fifo_dma_test;
	logic        SYS_CLK = 0, RST = 1, DMA_MODE = 0, AUTO_MODE = 0;
	logic        CTS_CHANGE_IRQ_ENABLE = 0, BUS_CS = 0, tb_rd = 0;
	logic        RECEIVE_BLOCK_RELEASE_CMD = 0, RX_START = 0, TX_LOAD = 0;
	logic        RX_VALID = 0, RX_END = 0, TX_READY = 0, REPEAT_DONE = 0;
	logic        CTS_N = 1, m_en = 0, m_slow = 0, got = 0;
	logic [4:0]  cz = '0;
	logic [5:0]  BUS_ADDR = '0;
	logic [7:0]  RX_DATA = '0, BUS_RDATA, m_wd, TX_DATA, rxq[$], txq[$];
	logic [11:0] TX_COUNT = '0;
	logic        m_ack, m_rd, m_wr, RX_READY, TX_VALID;
	wire  [8:0]  mon;
	int          bad_count = 0, total_checks = 0, nwr = 0, w;
	////////////////////////////////////////////////////////////////////
	// Device; requests and interrupts land on mon
	hdlc_fifo_dma dut (.SYS_CLK(SYS_CLK), .RST(RST), .CE(1'b1),
		.DMA_MODE(DMA_MODE), .AUTO_MODE(AUTO_MODE),
		.CTS_CHANGE_IRQ_ENABLE(CTS_CHANGE_IRQ_ENABLE), .BUS_CS(BUS_CS),
		.BUS_RD(tb_rd | m_rd), .BUS_WR(m_wr), .BUS_ADDR(BUS_ADDR),
		.BUS_WDATA(m_wd), .BUS_RDATA(BUS_RDATA),
		.DMA_ACKNOWLEDGE_INPUT(m_ack), .RECEIVE_DMA_REQUEST(mon[0]),
		.TRANSMIT_DMA_REQUEST(mon[1]),
		.RECEIVE_BLOCK_RELEASE_CMD(RECEIVE_BLOCK_RELEASE_CMD),
		.RX_START(RX_START), .RX_VALID(RX_VALID), .RX_END(RX_END),
		.RX_DATA(RX_DATA), .RX_READY(RX_READY), .TX_LOAD(TX_LOAD),
		.TX_COUNT(TX_COUNT), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA),
		.TX_READY(TX_READY), .FRAME_RR(cz[0]), .FRAME_RNR(cz[1]),
		.FRAME_NR_BAD(cz[2]), .FRAME_S_IFIELD(cz[3]),
		.TIMER_EXPIRE(cz[4]), .REPEAT_DONE(REPEAT_DONE), .CTS_N(CTS_N),
		.RECEIVE_POOL_FULL_IRQ(mon[2]), .RECEIVE_MESSAGE_END_IRQ(mon[3]),
		.RECEIVE_FRAME_OVERFLOW_IRQ(mon[4]),
		.PEER_STATUS_CHANGE_IRQ(mon[5]), .PROTOCOL_ERROR_IRQ(mon[6]),
		.TIMER_EXPIRED_IRQ(mon[7]), .CTS_CHANGE_IRQ(mon[8]));
	// DMA controller on the bus side
	dma_ctrl_model dma (.clk(SYS_CLK), .en(m_en), .slow(m_slow),
		.rx_req(mon[0]), .tx_req(mon[1]), .ack(m_ack), .rd(m_rd),
		.wr(m_wr), .wd(m_wd));
	// Clock
	initial forever #5 SYS_CLK = ~SYS_CLK;
	// Log DMA read bytes, DMA writes and serial bytes
	always @(posedge SYS_CLK) begin
		if (got)
			rxq.push_back(BUS_RDATA);
		got <= m_ack & m_rd;
		if (m_ack & m_wr)
			nwr++;
		if (TX_VALID && TX_READY)
			txq.push_back(TX_DATA);
	end
	////////////////////////////////////////////////////////////////////
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report
	task automatic chk(input string nm, input logic [11:0] e, g);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic tick(input int n = 1);
		repeat (n) @(posedge SYS_CLK);
		#1;
	endtask : tick
	// Watch one mon bit for lim edges; a missing event ends the run
	task automatic see(input int k, lim, input logic e);
		logic s = 0;
		for (int i = 0; i < lim; i++) begin
			s |= (mon[k] === 1'b1);
			if (e && s)
				break;
			tick();
		end
		chk("event", {3'h0, k[7:0], e}, {3'h0, k[7:0], s});
		if (e && !s)
			final_report();
	endtask : see
	// Stream n bytes from b; e marks the last one as status
	task automatic push(input logic [7:0] b, input int n, input logic e);
		for (int i = 0; i < n; i++) begin
			RX_VALID = 1;
			RX_DATA = b + i[7:0];
			RX_END = e && i == n - 1;
			for (w = 0; w < 500 && RX_READY !== 1'b1; w++)
				tick();
			if (RX_READY !== 1'b1) begin
				chk("rx_ready", 12'h001, {11'h0, RX_READY});
				final_report();
			end
			tick();
		end
		RX_VALID = 0;
		RX_END = 0;
	endtask : push
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		BUS_CS = 1;
		tb_rd = 1;
		BUS_ADDR = a;
		tick();
		BUS_CS = 0;
		tb_rd = 0;
		tick();
		chk("rdata", {4'h0, e}, {4'h0, BUS_RDATA});
	endtask : rd
	// One-cycle event input k, then watch mon bit b
	task automatic ev(input int k, b, input logic e);
		cz[k] = 1;
		tick();
		cz = '0;
		see(b, 4, e);
	endtask : ev
	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		tick(4);
		RST = 0;
		chk("reset", 12'h001, {2'h0, mon, RX_READY});
		chk("rdata0", 12'h000, {4'h0, BUS_RDATA});
		push(8'h00, 32, 0);
		see(2, 40, 1);
		chk("rxreq", 12'h000, {11'h0, mon[0]});
		rd(6'h05, 8'h05);
		rd(6'h05, 8'h05);
		rd(6'h1f, 8'h1f);
		push(8'h20, 32, 0);
		tick(8);
		RX_START = 1;
		tick();
		RX_START = 0;
		see(4, 4, 1);
		RECEIVE_BLOCK_RELEASE_CMD = 1;
		tick();
		RECEIVE_BLOCK_RELEASE_CMD = 0;
		see(2, 10, 1);
		rd(6'h00, 8'h20);
		RECEIVE_BLOCK_RELEASE_CMD = 1;
		tick();
		RECEIVE_BLOCK_RELEASE_CMD = 0;
		DMA_MODE = 1;
		push(8'h40, 3, 1);
		see(0, 10, 1);
		see(3, 8, 0);
		m_en = 1;
		see(3, 20, 1);
		m_slow = 1;
		push(8'h80, 64, 0);
		for (w = 0; w < 2000 && rxq.size() < 67; w++)
			tick();
		tick(8); // A surplus read would log one more byte
		chk("rxcnt", 12'd67, rxq.size());
		for (int i = 0; i < rxq.size(); i++)
			chk("rxbyte", i < 3 ? 12'h040 + i : 12'h07d + i,
				{4'h0, rxq[i]});
		chk("rxreq", 12'h000, {11'h0, mon[0]});
		TX_COUNT = 12'h022;
		TX_LOAD = 1;
		tick();
		TX_LOAD = 0;
		see(1, 5, 1);
		for (w = 0; w < 500 && nwr < 34; w++)
			tick();
		m_slow = 0;
		tick(4);
		chk("txreq", 12'h000, {11'h0, mon[1]});
		TX_READY = 1;
		for (w = 0; w < 2000 && txq.size() < 34; w++)
			tick();
		chk("writes", 12'h022, nwr);
		chk("txcnt", 12'h022, txq.size());
		for (int i = 0; i < txq.size(); i++)
			chk("txbyte", 12'h0a0 + i, {4'h0, txq[i]});
		for (int m = 0; m < 2; m++) begin
			AUTO_MODE = m[0];
			CTS_CHANGE_IRQ_ENABLE = ~m[0];
			ev(1, 5, m[0]);
			ev(0, 5, m[0]);
			ev(0, 5, 0);
			ev(2, 6, m[0]);
			ev(3, 6, m[0]);
			REPEAT_DONE = 0;
			ev(4, 7, 0);
			REPEAT_DONE = 1;
			ev(4, 7, 1);
			CTS_N = ~CTS_N;
			see(8, 8, ~m[0]);
		end
		final_report();
	end
endmodule : hdlc_fifo_dma_test
